// >>> design/dfm_top.sv
// Purpose: fault supervision for the head positioner and spindle
// Assumes: all pin inputs synchronous to clk_in; AHB-Lite single words
// Notes:   commands are issued by writing the command register
//
// How it works
// - cylinder above 822 raises bad track flag and is not loaded
// - illegal address or repeated seek shows seek check as status bit 2
// - seek check set on seek with illegal cylinder or moving heads
// - seek check cleared by seek home low or a legal seek
// - head above 4 sets illegal head on address command, head kept
// - sector above 47 sets illegal sector on address or transfer command
// - soft clear from power-on, run switch or status clear
// - each seek starts a 90 ms timeout, cancelled when heads settle
// - timeout counter advances on the spindle tick
// - load, unload or recal start 1250 ms timeout
// - unload timeout cancelled only by carriage back
// - expiry raises timeout fault, blocks counter reset, full shutdown
// - after expiry, timeout counter reset only by the hard clear
// - fault: lamp, status bit 4, unload, drop ready, disable servo
// - timeout fault after carriage back stops spindle, unlocks door
// - gain loss while on track sets gain fault, steps one to five
// - gain fault cleared by the soft clear
// - carriage back with ready set raises carriage back fault
// - carriage back fault cleared only by the hard clear
`timescale 1ns/100ps
module dfm_top
#(
    parameter int SEEK_TICKS = dfm_pkg::SEEK_TICKS,
    parameter int LONG_TICKS = dfm_pkg::LONG_TICKS
)
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        power_on_start_in,
    input  wire logic        run_switch_in,
    input  wire logic        seek_home_n_in,
    input  wire logic        access_not_settled_in,
    input  wire logic        carriage_back_in,
    input  wire logic        servo_gain_in,
    input  wire logic        spindle_tick_in,
    output logic             head_retract_out,
    output logic             drive_ready_out,
    output logic             ready_lamp_n_out,
    output logic             fault_lamp_n_out,
    output logic             servo_disable_out,
    output logic             spindle_run_out,
    output logic             stop_spindle_n_out,
    output logic             spindle_down_n_out,
    output logic             door_unlock_out,
    output logic             door_unlocked_n_out,
    output logic             timeout_fault_n_out,
    output logic             gain_loss_fault_n_out,
    output logic             carriage_back_fault_n_out
);
    import dfm_pkg::*;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       cmd_valid;
    dfm_op_t    op;
    logic [15:0] cmd_data;
    logic [31:0] status_word;
    logic [31:0] addr_word;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wr_pend       <= 1'b0;
            wr_addr       <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
        else
        begin
            wr_pend <= 1'b0;
            // zero wait states; read data is fetched in the address phase
            if (hsel_in && htrans_in[1] && hready_in)
            begin
                wr_addr <= haddr_in[7:0];
                wr_pend <= hwrite_in && (hsize_in == 3'h2);
                if (!hwrite_in && haddr_in[7:0] == STAT_OFS)
                    hrdata_out <= status_word;
                else if (!hwrite_in && haddr_in[7:0] == ADDR_OFS)
                    hrdata_out <= addr_word;
                else
                    hrdata_out <= 32'h0000_0000;
            end
        end
    end

    assign cmd_valid = wr_pend && (wr_addr == CMD_OFS);
    assign op        = dfm_op_t'(hwdata_in[CMD_OP_LSB +: 3]);
    assign cmd_data  = hwdata_in[15:0];

    // ------------------------------------------------------------
    // command decode and clears
    // ------------------------------------------------------------
    logic is_seek, is_addr, is_xfer, is_clear, is_recal, is_unload;
    logic pwr_q, run_q, home_q, tick_q;
    logic soft_clear, hard_clear, load_start, tick;
    logic cyl_bad, head_bad, sector_bad;

    assign is_seek   = cmd_valid && op == OP_SEEK;
    assign is_addr   = cmd_valid && op == OP_ADDRESS;
    assign is_xfer   = cmd_valid && op == OP_SECTOR_XFER;
    assign is_clear  = cmd_valid && op == OP_STATUS_CLEAR;
    assign is_recal  = cmd_valid && op == OP_RECAL;
    assign is_unload = cmd_valid && op == OP_UNLOAD;

    assign cyl_bad    = cmd_data[9:0] > CYL_TOP;
    assign head_bad   = cmd_data[10:8] > HEAD_TOP;
    assign sector_bad = cmd_data[5:0] > SECTOR_TOP;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pwr_q  <= 1'b0;
            run_q  <= 1'b0;
            home_q <= 1'b1;
            tick_q <= 1'b0;
        end
        else
        begin
            pwr_q  <= power_on_start_in;
            run_q  <= run_switch_in;
            home_q <= seek_home_n_in;
            tick_q <= spindle_tick_in;
        end
    end

    // hard clear only on power-on start or run switch, never on status clear
    assign hard_clear = (power_on_start_in && !pwr_q) || (run_switch_in && !run_q);
    assign soft_clear = hard_clear || is_clear;
    assign load_start = home_q && !seek_home_n_in;
    assign tick       = spindle_tick_in && !tick_q;

    // ------------------------------------------------------------
    // address registers and address checks
    // ------------------------------------------------------------
    logic [9:0] track_clear_pulse;
    logic [2:0] head;
    logic [5:0] sector;
    logic       bad_track_flag, seek_check, ill_head, ill_sector;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            track_clear_pulse <= CYL_HOME;
        else if (is_seek && !cyl_bad)
            track_clear_pulse <= cmd_data[9:0];
        else if (is_recal || load_start)
            track_clear_pulse <= CYL_HOME;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            bad_track_flag <= 1'b0;
        else if (is_seek)
            bad_track_flag <= cyl_bad;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            seek_check <= 1'b0;
        else if (is_seek && (cyl_bad || access_not_settled_in))
            seek_check <= 1'b1;
        else if (soft_clear || !seek_home_n_in || is_seek)
            seek_check <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            head     <= 3'h0;
            ill_head <= 1'b0;
        end
        else if (is_addr && head_bad)
            ill_head <= 1'b1;
        else
        begin
            if (is_addr)
                head <= cmd_data[10:8];
            if (soft_clear)
                ill_head <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sector     <= 6'h00;
            ill_sector <= 1'b0;
        end
        else if ((is_addr || is_xfer) && sector_bad)
            ill_sector <= 1'b1;
        else
        begin
            if (is_addr || is_xfer)
                sector <= cmd_data[5:0];
            if (soft_clear)
                ill_sector <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // timeout supervision
    // ------------------------------------------------------------
    logic      t_start, t_long, t_cancel, t_busy, t_expired;
    logic      kind_unload, kind_long, moved;
    dfm_shut_t state;
    logic      gain_fault, cb_fault, fault_any, ready, retract;

    // fault entry starts a normal unload, unless it is the timeout itself
    assign t_start  = is_seek || is_recal || load_start || is_unload
                    || (state == SD_IDLE && fault_any && !t_expired);
    assign t_long   = !is_seek;
    // moved guards against cancelling before the actuator has responded
    assign t_cancel = kind_unload ? (retract && carriage_back_in)
                                  : (moved && !access_not_settled_in);

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            kind_unload <= 1'b0;
            kind_long   <= 1'b0;
            moved       <= 1'b0;
        end
        else if (t_start)
        begin
            kind_unload <= !is_seek && !is_recal && !load_start;
            kind_long   <= !is_seek;
            moved       <= 1'b0;
        end
        else if (access_not_settled_in)
            moved <= 1'b1;
    end

    dfm_timeout #(
        .SEEK_TICKS (SEEK_TICKS),
        .LONG_TICKS (LONG_TICKS),
        .CW         (8)
    ) u_timeout (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .hard_clear_in (hard_clear),
        .start_in      (t_start),
        .long_in       (t_long),
        .tick_in       (tick),
        .cancel_in     (t_cancel),
        .busy_out      (t_busy),
        .expired_out   (t_expired)
    );

    // ------------------------------------------------------------
    // gain loss and carriage back faults
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            gain_fault <= 1'b0;
        else if (!servo_gain_in && ready && track_clear_pulse <= CYL_TOP)
            gain_fault <= 1'b1;
        else if (soft_clear)
            gain_fault <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            cb_fault <= 1'b0;
        else if (carriage_back_in && ready)
            cb_fault <= 1'b1;
        else if (hard_clear)
            cb_fault <= 1'b0;
    end

    assign fault_any = t_expired || gain_fault || cb_fault;

    // ------------------------------------------------------------
    // shutdown sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            state <= SD_IDLE;
        else
        begin
            case (state)
                SD_IDLE:
                    if (fault_any)
                        state <= SD_RETRACT;
                SD_RETRACT:
                    if (carriage_back_in)
                        state <= t_expired ? SD_SPIN_STOP : SD_HALTED;
                SD_SPIN_STOP:
                    state <= SD_HALTED;
                SD_HALTED:
                    if (!fault_any)
                        state <= SD_IDLE;
                default:
                    state <= SD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            retract <= 1'b0;
        else if (is_unload || (state == SD_IDLE && fault_any))
            retract <= 1'b1;
        else if (load_start && !fault_any)
            retract <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            ready <= 1'b0;
        else if (retract || fault_any || state != SD_IDLE)
            ready <= 1'b0;
        // kind of the running timer, not the command on the bus: a seek never sets ready
        else if (t_busy && t_cancel && kind_long && !kind_unload)
            ready <= 1'b1;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            spindle_run_out <= 1'b0;
        else if (state == SD_SPIN_STOP)
            spindle_run_out <= 1'b0;
        else if (run_switch_in && !run_q)
            spindle_run_out <= 1'b1;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            head_retract_out          <= 1'b0;
            drive_ready_out           <= 1'b0;
            ready_lamp_n_out          <= 1'b1;
            fault_lamp_n_out          <= 1'b1;
            servo_disable_out         <= 1'b0;
            stop_spindle_n_out        <= 1'b1;
            spindle_down_n_out        <= 1'b1;
            door_unlock_out           <= 1'b0;
            door_unlocked_n_out       <= 1'b1;
            timeout_fault_n_out       <= 1'b1;
            gain_loss_fault_n_out     <= 1'b1;
            carriage_back_fault_n_out <= 1'b1;
        end
        else
        begin
            head_retract_out          <= retract;
            drive_ready_out           <= ready;
            ready_lamp_n_out          <= !ready;
            fault_lamp_n_out          <= state == SD_IDLE;
            servo_disable_out         <= state != SD_IDLE;
            stop_spindle_n_out        <= !(state == SD_SPIN_STOP || (state == SD_HALTED && t_expired));
            spindle_down_n_out        <= !(state == SD_SPIN_STOP || (state == SD_HALTED && t_expired));
            door_unlock_out           <= state == SD_SPIN_STOP || (state == SD_HALTED && t_expired);
            door_unlocked_n_out       <= !(state == SD_SPIN_STOP || (state == SD_HALTED && t_expired));
            timeout_fault_n_out       <= !t_expired;
            gain_loss_fault_n_out     <= !gain_fault;
            carriage_back_fault_n_out <= !cb_fault;
        end
    end

    // ------------------------------------------------------------
    // readback words
    // ------------------------------------------------------------
    always_comb
    begin
        status_word                = 32'h0000_0000;
        status_word[ST_READY]      = ready;
        status_word[ST_ILL_HEAD]   = ill_head;
        status_word[ST_SEEK_CHECK] = seek_check || ill_head || ill_sector;
        status_word[ST_ILL_SECTOR] = ill_sector;
        status_word[ST_DRV_FAULT]  = state != SD_IDLE;
        status_word[ST_BAD_TRACK]  = bad_track_flag;
        status_word[ST_TIMEOUT]    = t_expired;
        status_word[ST_GAIN_LOSS]  = gain_fault;
        status_word[ST_CB_FAULT]   = cb_fault;
        status_word[ST_TIMING]     = t_busy;
        status_word[ST_RETRACT]    = retract;
        addr_word                  = 32'h0000_0000;
        addr_word[9:0]             = track_clear_pulse;
        addr_word[ADDR_HEAD_LSB +: 3]   = head;
        addr_word[ADDR_SECTOR_LSB +: 6] = sector;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb_clk @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence fault_entry_s;
        state == SD_IDLE && fault_any;
    endsequence

    sequence retracted_s;
        state == SD_RETRACT && carriage_back_in && t_expired;
    endsequence

    cyl_block_a: assert property (is_seek && cyl_bad |=> track_clear_pulse == $past(track_clear_pulse))
        else $error("illegal cylinder was loaded");
    seek_check_a: assert property (is_seek && cyl_bad |=> seek_check && status_word[2])
        else $error("seek check missing after illegal seek");
    busy_seek_a: assert property (is_seek && access_not_settled_in |=> seek_check)
        else $error("seek check missing for repeated seek");
    home_clear_a: assert property (!is_seek && !seek_home_n_in |=> !seek_check)
        else $error("seek home did not clear seek check");
    head_keep_a: assert property (is_addr && head_bad |=> ill_head && head == $past(head))
        else $error("illegal head handling wrong");
    sector_keep_a: assert property ((is_addr || is_xfer) && sector_bad
                                    |=> ill_sector && sector == $past(sector))
        else $error("illegal sector handling wrong");
    soft_clear_a: assert property (is_clear |=> !ill_head && !ill_sector)
        else $error("status clear left address flags set");
    expire_block_a: assert property (t_expired && !hard_clear |=> t_expired)
        else $error("timeout fault reset without hard clear");
    fault_seq_a: assert property (fault_entry_s |=> ##1 !fault_lamp_n_out && head_retract_out
                                  && servo_disable_out && !drive_ready_out)
        else $error("shutdown steps missing");
    spin_stop_a: assert property (retracted_s |-> ##[1:3] !stop_spindle_n_out
                                  && !door_unlocked_n_out)
        else $error("spindle not stopped after timeout retract");
    gain_set_a: assert property (!servo_gain_in && ready |=> ##1 !gain_loss_fault_n_out)
        else $error("gain loss not flagged");
    cb_hold_a: assert property (cb_fault && !hard_clear |=> cb_fault)
        else $error("carriage back fault cleared by soft clear");

endmodule

// >>> shared/dfm_pkg.sv
// Purpose: constants and types shared by the drive fault monitor
// Assumes: 40 MHz system clock, 180 Hz spindle tick
// Notes:   register offsets are byte addresses on the AHB-Lite slave
package dfm_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] ADDR_OFS = 8'h08;

    // command word: data in [15:0], opcode in [18:16]
    localparam int CMD_OP_LSB = 16;

    // address readback layout
    localparam int ADDR_HEAD_LSB   = 16;
    localparam int ADDR_SECTOR_LSB = 24;

    // status bit positions
    localparam int ST_READY      = 0;
    localparam int ST_ILL_HEAD   = 1;
    localparam int ST_SEEK_CHECK = 2;
    localparam int ST_ILL_SECTOR = 3;
    localparam int ST_DRV_FAULT  = 4;
    localparam int ST_BAD_TRACK  = 5;
    localparam int ST_TIMEOUT    = 6;
    localparam int ST_GAIN_LOSS  = 7;
    localparam int ST_CB_FAULT   = 8;
    localparam int ST_TIMING     = 9;
    localparam int ST_RETRACT    = 10;

    // ------------------------------------------------------------
    // address limits
    // ------------------------------------------------------------
    localparam logic [9:0] CYL_TOP    = 10'h336;
    localparam logic [2:0] HEAD_TOP   = 3'h4;
    localparam logic [5:0] SECTOR_TOP = 6'h2F;
    localparam logic [9:0] CYL_HOME   = 10'h000;

    // ------------------------------------------------------------
    // timing: limits in ms, counts in spindle ticks, rounded up
    // ------------------------------------------------------------
    localparam int TICK_HZ      = 180;
    localparam int SEEK_TIME_MS = 90;
    localparam int LONG_TIME_MS = 1250;
    localparam int SEEK_TICKS   = (SEEK_TIME_MS * TICK_HZ + 999) / 1000;
    localparam int LONG_TICKS   = (LONG_TIME_MS * TICK_HZ + 999) / 1000;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_SEEK,
        OP_ADDRESS,
        OP_SECTOR_XFER,
        OP_STATUS_CLEAR,
        OP_RECAL,
        OP_UNLOAD
    } dfm_op_t;

    typedef enum logic [1:0] {
        SD_IDLE,
        SD_RETRACT,
        SD_SPIN_STOP,
        SD_HALTED
    } dfm_shut_t;

endpackage

// >>> design/dfm_timeout.sv
// Purpose: timeout counter clocked by the spindle tick
// Assumes: tick_in is a one-cycle enable pulse
// Notes:   once expired, only the hard clear restarts the counter
`timescale 1ns/100ps
module dfm_timeout
#(
    parameter int SEEK_TICKS = dfm_pkg::SEEK_TICKS,
    parameter int LONG_TICKS = dfm_pkg::LONG_TICKS,
    parameter int CW         = 8
)
(
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic hard_clear_in,
    input  wire logic start_in,
    input  wire logic long_in,
    input  wire logic tick_in,
    input  wire logic cancel_in,
    output logic      busy_out,
    output logic      expired_out
);
    import dfm_pkg::*;

    logic [CW-1:0] count;
    logic [CW-1:0] limit;

    if (SEEK_TICKS < 1 || LONG_TICKS < 1 || LONG_TICKS >= 2 ** CW || SEEK_TICKS >= 2 ** CW)
    begin : g_bad
        $error("dfm_timeout: tick counts do not fit the counter");
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            busy_out    <= 1'b0;
            expired_out <= 1'b0;
            count       <= '0;
            limit       <= '0;
        end
        else if (hard_clear_in)
        begin
            busy_out    <= 1'b0;
            expired_out <= 1'b0;
            count       <= '0;
        end
        else if (expired_out)
        begin
            busy_out <= 1'b0;
        end
        else if (start_in)
        begin
            busy_out <= 1'b1;
            count    <= '0;
            limit    <= long_in ? CW'(LONG_TICKS) : CW'(SEEK_TICKS);
        end
        else if (busy_out && cancel_in)
        begin
            busy_out <= 1'b0;
        end
        else if (busy_out && tick_in)
        begin
            count <= count + 1'b1;
            if (count == limit - 1'b1)
            begin
                expired_out <= 1'b1;
                busy_out    <= 1'b0;
            end
        end
    end

endmodule

// >>> verification/dfm_drive_model.sv
// Purpose: drive mechanics behind the fault monitor
// Assumes: one clock, tick made from a cycle divider
// Notes:   carriage lands a fixed lag after retract
`timescale 1ns/100ps
module dfm_drive_model
#(
    parameter int TICK_GAP = 40
)
(
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic head_retract_in,
    output logic      spindle_tick_out,
    output logic      carriage_back_out
);
    int cnt;
    int lag;
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt <= 0;
            lag <= 0;
            spindle_tick_out <= 1'b0;
            carriage_back_out <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == TICK_GAP - 1) ? 0 : cnt + 1;
            spindle_tick_out <= (cnt == 0);
            // slow retract so a fault is seen before the carriage lands
            lag <= head_retract_in ? ((lag < 8) ? lag + 1 : lag) : 0;
            carriage_back_out <= (lag == 8);
        end
    end
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench of the drive fault monitor
// Assumes: short timer counts, tick every 40 cycles
// Notes:   gain and home inputs held idle
`timescale 1ns/100ps
module testbench;
    import dfm_pkg::*;
    logic clk_in, rst_b_in, hsel_in, hwrite_in, run_switch_in, access_not_settled_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, r, seed;
    logic [1:0] htrans_in;
    logic [2:0] h, eh;
    logic [5:0] s, es;
    logic hreadyout_out, hresp_out, head_retract_out, drive_ready_out, ready_lamp_n_out;
    logic fault_lamp_n_out, servo_disable_out, spindle_run_out, stop_spindle_n_out;
    logic spindle_down_n_out, door_unlock_out, door_unlocked_n_out, timeout_fault_n_out;
    logic gain_loss_fault_n_out, carriage_back_fault_n_out, spindle_tick_in, carriage_back_in;
    wire hready_in = hreadyout_out;
    wire [2:0] hsize_in = 3'h2;
    wire servo_gain_in = 1'b1;
    wire power_on_start_in = 1'b0;
    wire seek_home_n_in = 1'b1;
    int bad_count = 0;
    int total_checks = 0;
    int i;
    dfm_top #(.SEEK_TICKS(3), .LONG_TICKS(5)) i_dfm_top (.*);
    dfm_drive_model i_dfm_drive_model (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .head_retract_in(head_retract_out), .spindle_tick_out(spindle_tick_in),
        .carriage_back_out(carriage_back_in));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= {24'h0, a};
        htrans_in <= 2'h2;
        hwrite_in <= w;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        r = hrdata_out;
    endtask
    task automatic cmd(input dfm_op_t op, input logic [15:0] d);
        xfer(1'b1, CMD_OFS, {13'h0, op, d});
    endtask
    task automatic settle();
        access_not_settled_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        access_not_settled_in <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        tally_and_finish();
    end
    initial
    begin
        {rst_b_in, hsel_in, hwrite_in, run_switch_in, access_not_settled_in} = 5'h0;
        {haddr_in, hwdata_in, htrans_in, seed, eh, es} = {64'h0, 2'h0, 32'h1F, 9'h0};
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        run_switch_in <= 1'b1;
        @(posedge clk_in);
        // random address and transfer commands, boundaries first
        for (i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            {h, s} = (i == 0) ? 9'h12F : (i == 1) ? 9'h170 : seed[8:0];
            cmd(OP_STATUS_CLEAR, 16'h0);
            cmd(seed[9] ? OP_SECTOR_XFER : OP_ADDRESS, {5'h0, h, 2'h0, s});
            if (!seed[9] && h <= HEAD_TOP) eh = h;
            if (s <= SECTOR_TOP) es = s;
            xfer(1'b0, ADDR_OFS, 32'h0);
            chk(32'({r[18:16], r[29:24]}), 32'({eh, es}));
            xfer(1'b0, STAT_OFS, 32'h0);
            chk(32'(r[3:1]), 32'({s > SECTOR_TOP, (!seed[9] && h > HEAD_TOP) || s > SECTOR_TOP,
                !seed[9] && h > HEAD_TOP}));
        end
        cmd(OP_SEEK, 16'h0336);
        settle();
        cmd(OP_SEEK, 16'h0337);
        xfer(1'b0, ADDR_OFS, 32'h0);
        chk(32'(r[9:0]), 32'h336);
        xfer(1'b0, STAT_OFS, 32'h0);
        chk(32'({r[ST_BAD_TRACK], r[ST_SEEK_CHECK]}), 32'h3);
        settle();
        cmd(OP_SEEK, 16'h0100);
        xfer(1'b0, STAT_OFS, 32'h0);
        chk(32'(r[ST_SEEK_CHECK]), 32'h0);
        access_not_settled_in <= 1'b1;
        cmd(OP_SEEK, 16'h0005);
        xfer(1'b0, STAT_OFS, 32'h0);
        chk(32'(r[ST_SEEK_CHECK]), 32'h1);
        settle();
        cmd(OP_STATUS_CLEAR, 16'h0);
        xfer(1'b0, STAT_OFS, 32'h0);
        chk(32'(r[ST_SEEK_CHECK]), 32'h0);
        cmd(OP_RECAL, 16'h0);
        settle();
        chk(32'(drive_ready_out), 32'h1);
        // seek with heads never moving runs out: three ticks of 40 cycles
        cmd(OP_SEEK, 16'h0010);
        for (i = 0; i < 400 && timeout_fault_n_out !== 1'b0; i++) @(posedge clk_in);
        chk(32'(i > 78 && i < 125), 32'h1);
        repeat (3) @(posedge clk_in);
        chk(32'({head_retract_out, fault_lamp_n_out, ready_lamp_n_out, servo_disable_out,
            drive_ready_out, door_unlocked_n_out}), 32'h2D);
        for (i = 0; i < 200 && door_unlocked_n_out !== 1'b0; i++) @(posedge clk_in);
        chk(32'({stop_spindle_n_out, spindle_down_n_out, spindle_run_out, door_unlock_out,
            carriage_back_fault_n_out}), 32'h3);
        cmd(OP_STATUS_CLEAR, 16'h0);
        xfer(1'b0, STAT_OFS, 32'h0);
        chk(32'({r[ST_TIMEOUT], r[ST_DRV_FAULT]}), 32'h3);
        run_switch_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        run_switch_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(32'({timeout_fault_n_out, spindle_run_out, hresp_out}), 32'h6);
        tally_and_finish();
    end
endmodule
